// file: shared/otlh_pkg.sv
// package for the overtravel limit handler: offsets, fields, reset values, types
package otlh_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register byte addresses
	localparam logic [4:0] OTLH_ADDR_CFG = 5'h00;
	localparam logic [4:0] OTLH_ADDR_FORCE = 5'h04;
	localparam logic [4:0] OTLH_ADDR_STATUS = 5'h08;
	localparam logic [4:0] OTLH_ADDR_IRQ_STAT = 5'h0c;
	localparam logic [4:0] OTLH_ADDR_IRQ_MASK = 5'h10;
	localparam logic [4:0] OTLH_ADDR_CMD = 5'h14;
	localparam logic [4:0] OTLH_ADDR_CODE = 5'h18;
	localparam int OTLH_AW = 5;

	////////////////////////////////////////////////////////////////////////////
	// configuration digits and their values
	localparam logic [3:0] OTLH_FWD_USE_INPUT = 4'h1;
	localparam logic [3:0] OTLH_REV_USE_INPUT = 4'h2;
	localparam logic [3:0] OTLH_LIMIT_DISABLED = 4'h8;
	localparam logic [3:0] OTLH_STOP_LO_RST = 4'h0;
	localparam logic [3:0] OTLH_STOP_HI_RST = 4'h0;
	localparam logic [3:0] OTLH_WARN_DET_ON = 4'h1;
	localparam logic [3:0] OTLH_WARN_DET_RST = 4'h0;

	// field positions inside the configuration word
	localparam int OTLH_CFG_FWD_LSB = 0;
	localparam int OTLH_CFG_REV_LSB = 4;
	localparam int OTLH_CFG_STOP_LO_LSB = 8;
	localparam int OTLH_CFG_STOP_HI_LSB = 12;
	localparam int OTLH_CFG_WARN_LSB = 16;
	localparam int OTLH_CFG_W = 20;

	// command register bits
	localparam int OTLH_CMD_CLR_WARN = 0;
	localparam int OTLH_CMD_RESTART = 1;

	// interrupt status bits
	localparam int OTLH_IRQ_WARN = 0;
	localparam int OTLH_IRQ_FWD_OT = 1;
	localparam int OTLH_IRQ_REV_OT = 2;
	localparam int OTLH_IRQ_W = 3;

	////////////////////////////////////////////////////////////////////////////
	// emergency stop force, percent of rated force
	localparam int OTLH_FORCE_W = 10;
	localparam logic [9:0] OTLH_FORCE_MAX = 10'h320;
	localparam logic [9:0] OTLH_FORCE_RST = 10'h320;

	// overtravel warning code as reported to the host
	localparam logic [11:0] OTLH_WARN_CODE = 12'h9a0;

	////////////////////////////////////////////////////////////////////////////
	// types
	typedef struct packed {
		logic [3:0] warn_det;
		logic [3:0] stop_hi;
		logic [3:0] stop_lo;
		logic [3:0] rev_cfg;
		logic [3:0] fwd_cfg;
	} otlh_cfg_s;

	localparam otlh_cfg_s OTLH_CFG_RST = '{
		warn_det: OTLH_WARN_DET_RST,
		stop_hi: OTLH_STOP_HI_RST,
		stop_lo: OTLH_STOP_LO_RST,
		rev_cfg: OTLH_REV_USE_INPUT,
		fwd_cfg: OTLH_FWD_USE_INPUT
	};

	typedef enum logic [1:0] {
		OTLH_M_NONE = 2'h0,
		OTLH_M_BRAKE = 2'h1,
		OTLH_M_COAST = 2'h2,
		OTLH_M_DECEL = 2'h3
	} otlh_method_e;

	typedef enum logic [1:0] {
		OTLH_H_NONE = 2'h0,
		OTLH_H_BRAKE = 2'h1,
		OTLH_H_COAST = 2'h2,
		OTLH_H_CLAMP = 2'h3
	} otlh_hold_e;

	typedef enum logic [2:0] {
		OTLH_ST_IDLE = 3'b001,
		OTLH_ST_STOP = 3'b010,
		OTLH_ST_HOLD = 3'b100
	} otlh_state_e;

	typedef struct packed {
		otlh_method_e method;
		otlh_hold_e hold;
	} otlh_stop_s;

endpackage

// file: core/otlh_sync.sv
// two flip-flop synchroniser, one stage pair per bit
`timescale 1ns/10ps
module otlh_sync #(
	parameter int WIDTH = 2
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic meta_q;
			logic sync_q;
			// first stage feeds only the second stage
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					meta_q <= 1'b1; // closed-switch level: no false edge after reset
					sync_q <= 1'b1;
				end else begin
					meta_q <= async_i[g];
					sync_q <= meta_q;
				end
			end
			assign sync_o[g] = sync_q;
		end
	endgenerate

endmodule

// file: core/otlh_stop_sel.sv
// decodes the stop configuration into a stop method and a mode after stopping
`timescale 1ns/10ps
module otlh_stop_sel
	import otlh_pkg::*;
(
	input wire logic [3:0] stop_lo_i,
	input wire logic [3:0] stop_hi_i,
	input wire logic force_ctrl_i,
	output otlh_stop_s stop_o
);

	// low digit picks brake or coast, high digit may override with deceleration
	always_comb begin
		stop_o.method = OTLH_M_BRAKE;
		stop_o.hold = OTLH_H_BRAKE;
		case (stop_lo_i)
			4'h1: begin
				stop_o.method = OTLH_M_BRAKE;
				stop_o.hold = OTLH_H_COAST;
			end
			4'h2: begin
				stop_o.method = OTLH_M_COAST;
				stop_o.hold = OTLH_H_COAST;
			end
			default: begin
				stop_o.method = OTLH_M_BRAKE;
				stop_o.hold = OTLH_H_BRAKE;
			end
		endcase
		if (force_ctrl_i) begin
			stop_o.hold = OTLH_H_COAST;
		end else begin
			case (stop_hi_i)
				4'h1: begin
					stop_o.method = OTLH_M_DECEL;
					stop_o.hold = OTLH_H_CLAMP;
				end
				4'h2: begin
					stop_o.method = OTLH_M_DECEL;
					stop_o.hold = OTLH_H_COAST;
				end
				default: begin
				end
			endcase
		end
	end

endmodule

// file: core/otlh_top.sv
// overtravel limit handler: limit inputs, stop control, warning and register file
//
// Contract
// - forward limit on allows forward motion; off blocks it and flags forward overtravel.
// - reverse limit on allows reverse motion; off blocks it and flags reverse overtravel.
// - during overtravel, motion away from the active limit stays allowed.
// - forward input config: 1 uses input, 8 always allows; active after restart.
// - reverse input config: 2 uses input, 8 always allows; active after restart.
// - zero clamp holds position loop at reference zero; coast applies no control.
// - under force control no deceleration; brake or coast per low digit, then coast.
// - emergency stop force 0 to 800 percent, default 800, effective at once.
// - applied stop force never exceeds the motor maximum force.
// - with detection on, overtravel during motor power raises the warning, even momentary.
// - detection enabled when warning digit is 1; default 0 disables it.
// - warning only for overtravel in reference direction, never opposite.
// - with no reference, overtravel in either direction raises the warning.
// - no warning while motor power is off.
// - power turning on during existing overtravel raises no warning.
// - clear command clears warning anytime; no repeat until overtravel is removed and recurs.
// - exceeding an active software travel limit also raises the warning.
//
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module otlh_top
	import otlh_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	// limit switches and drive state
	input wire logic fwd_limit_in_i,
	input wire logic rev_limit_in_i,
	input wire logic motor_power_on_i,
	input wire logic force_ctrl_i,
	input wire logic motor_stopped_i,
	input wire logic soft_limit_exceeded_i,
	input wire logic [OTLH_FORCE_W-1:0] motor_max_force_i,
	// host motion reference direction
	input wire logic ref_fwd_i,
	input wire logic ref_rev_i,
	// register port
	input wire logic [OTLH_AW-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	output logic [31:0] reg_rdata_o,
	// motion permission and stop control
	output logic fwd_motion_en_o,
	output logic rev_motion_en_o,
	output logic fwd_overtravel_o,
	output logic rev_overtravel_o,
	output otlh_method_e stop_method_o,
	output otlh_hold_e hold_mode_o,
	output logic zero_clamp_o,
	output logic control_off_o,
	output logic [OTLH_FORCE_W-1:0] stop_force_o,
	output logic warn_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// declarations
	logic [1:0] limit_sync;
	logic fwd_in_s;
	logic rev_in_s;
	otlh_cfg_s cfg_shadow_q, cfg_shadow_d;
	otlh_cfg_s cfg_act_q, cfg_act_d;
	logic [OTLH_FORCE_W-1:0] force_q, force_d;
	logic [OTLH_IRQ_W-1:0] irq_stat_q, irq_stat_d;
	logic [OTLH_IRQ_W-1:0] irq_mask_q, irq_mask_d;
	logic [31:0] rdata_q, rdata_d;
	logic fwd_ot, rev_ot;
	logic fwd_ot_q, rev_ot_q, soft_q;
	logic fwd_rise, rev_rise, soft_rise;
	logic warn_q, warn_d, warn_set, warn_clr;
	logic restart;
	logic wr_cfg, wr_force, wr_stat, wr_mask, wr_cmd;
	otlh_stop_s stop_sel;
	otlh_state_e state_q, state_d;
	otlh_method_e method_q, method_d;
	otlh_hold_e hold_q, hold_d;
	logic stop_need;
	logic fwd_en_q, rev_en_q, fwd_otf_q, rev_otf_q;
	logic clamp_q, ctl_off_q;
	logic [OTLH_FORCE_W-1:0] sforce_q, sforce_d;
	logic irq_q;

	////////////////////////////////////////////////////////////////////////////
	// limit input synchronisers
	otlh_sync #(
		.WIDTH(2)
	) u_sync (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.async_i({rev_limit_in_i, fwd_limit_in_i}),
		.sync_o(limit_sync)
	);

	assign fwd_in_s = limit_sync[0];
	assign rev_in_s = limit_sync[1];

	// an input counts only when its active configuration does not disable it
	assign fwd_ot = (cfg_act_q.fwd_cfg != OTLH_LIMIT_DISABLED) && !fwd_in_s;
	assign rev_ot = (cfg_act_q.rev_cfg != OTLH_LIMIT_DISABLED) && !rev_in_s;

	////////////////////////////////////////////////////////////////////////////
	// register write decode
	assign wr_cfg = reg_we_i && (reg_addr_i == OTLH_ADDR_CFG);
	assign wr_force = reg_we_i && (reg_addr_i == OTLH_ADDR_FORCE);
	assign wr_stat = reg_we_i && (reg_addr_i == OTLH_ADDR_IRQ_STAT);
	assign wr_mask = reg_we_i && (reg_addr_i == OTLH_ADDR_IRQ_MASK);
	assign wr_cmd = reg_we_i && (reg_addr_i == OTLH_ADDR_CMD);
	assign restart = wr_cmd && reg_wdata_i[OTLH_CMD_RESTART];
	assign warn_clr = wr_cmd && reg_wdata_i[OTLH_CMD_CLR_WARN];

	// configuration: written into a shadow, limit and stop digits copied to the active set on restart; warning digit goes active at once
	always_comb begin
		cfg_shadow_d = cfg_shadow_q;
		cfg_act_d = cfg_act_q;
		force_d = force_q;
		irq_mask_d = irq_mask_q;
		if (wr_cfg) begin
			cfg_shadow_d = otlh_cfg_s'(reg_wdata_i[OTLH_CFG_W-1:0]);
			cfg_act_d.warn_det = reg_wdata_i[OTLH_CFG_WARN_LSB +: 4];
		end
		if (restart) begin
			cfg_act_d.fwd_cfg = cfg_shadow_q.fwd_cfg;
			cfg_act_d.rev_cfg = cfg_shadow_q.rev_cfg;
			cfg_act_d.stop_lo = cfg_shadow_q.stop_lo;
			cfg_act_d.stop_hi = cfg_shadow_q.stop_hi;
		end
		if (wr_force) begin
			// out-of-range settings saturate at the top of the range
			if (reg_wdata_i[31:0] > {22'h0, OTLH_FORCE_MAX}) begin
				force_d = OTLH_FORCE_MAX;
			end else begin
				force_d = reg_wdata_i[OTLH_FORCE_W-1:0];
			end
		end
		if (wr_mask) begin
			irq_mask_d = reg_wdata_i[OTLH_IRQ_W-1:0];
		end
	end

	// configuration registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_shadow_q <= OTLH_CFG_RST;
			cfg_act_q <= OTLH_CFG_RST;
			force_q <= OTLH_FORCE_RST;
			irq_mask_q <= '0;
		end else begin
			cfg_shadow_q <= cfg_shadow_d;
			cfg_act_q <= cfg_act_d;
			force_q <= force_d;
			irq_mask_q <= irq_mask_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// overtravel warning detection
	// edges only, so existing overtravel at power-on or after a clear stays silent
	assign fwd_rise = fwd_ot && !fwd_ot_q;
	assign rev_rise = rev_ot && !rev_ot_q;
	assign soft_rise = soft_limit_exceeded_i && !soft_q;

	always_comb begin
		warn_set = 1'b0;
		if ((cfg_act_q.warn_det == OTLH_WARN_DET_ON) && motor_power_on_i) begin
			if (fwd_rise && !ref_rev_i) begin
				warn_set = 1'b1;
			end
			if (rev_rise && !ref_fwd_i) begin
				warn_set = 1'b1;
			end
			if (soft_rise) begin
				warn_set = 1'b1;
			end
		end
		// a new event in the clearing cycle wins
		warn_d = warn_set || (warn_q && !warn_clr);
	end

	// warning flag and edge history
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			warn_q <= 1'b0;
			fwd_ot_q <= 1'b0;
			rev_ot_q <= 1'b0;
			soft_q <= 1'b0;
		end else begin
			warn_q <= warn_d;
			fwd_ot_q <= fwd_ot;
			rev_ot_q <= rev_ot;
			soft_q <= soft_limit_exceeded_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status: sticky, write one to clear, set wins
	always_comb begin
		irq_stat_d = irq_stat_q;
		if (wr_stat) begin
			irq_stat_d = irq_stat_q & ~reg_wdata_i[OTLH_IRQ_W-1:0];
		end
		if (warn_set) begin
			irq_stat_d[OTLH_IRQ_WARN] = 1'b1;
		end
		if (fwd_rise) begin
			irq_stat_d[OTLH_IRQ_FWD_OT] = 1'b1;
		end
		if (rev_rise) begin
			irq_stat_d[OTLH_IRQ_REV_OT] = 1'b1;
		end
	end

	// interrupt registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_stat_q <= '0;
			irq_q <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			irq_q <= |(irq_stat_d & irq_mask_d);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// stop method decode
	otlh_stop_sel u_stop_sel (
		.stop_lo_i(cfg_act_q.stop_lo),
		.stop_hi_i(cfg_act_q.stop_hi),
		.force_ctrl_i(force_ctrl_i),
		.stop_o(stop_sel)
	);

	// with motor power on, a stop is needed when overtravel blocks the way the reference heads, or no reference
	assign stop_need = motor_power_on_i &&
		((fwd_ot && !ref_rev_i) || (rev_ot && !ref_fwd_i));

	// stop sequence: idle, stopping, holding after stop
	always_comb begin
		state_d = state_q;
		method_d = method_q;
		hold_d = hold_q;
		case (state_q)
			OTLH_ST_IDLE: begin
				method_d = OTLH_M_NONE;
				hold_d = OTLH_H_NONE;
				if (stop_need) begin
					state_d = OTLH_ST_STOP;
					method_d = stop_sel.method;
				end
			end
			OTLH_ST_STOP: begin
				if (!stop_need) begin
					state_d = OTLH_ST_IDLE;
					method_d = OTLH_M_NONE;
				end else if (motor_stopped_i) begin
					state_d = OTLH_ST_HOLD;
					method_d = OTLH_M_NONE;
					hold_d = stop_sel.hold;
				end
			end
			OTLH_ST_HOLD: begin
				if (!stop_need) begin
					state_d = OTLH_ST_IDLE;
					hold_d = OTLH_H_NONE;
				end
			end
			default: begin
				state_d = OTLH_ST_IDLE;
				method_d = OTLH_M_NONE;
				hold_d = OTLH_H_NONE;
			end
		endcase
		// applied force limited to what the motor can give
		if (force_q > motor_max_force_i) begin
			sforce_d = motor_max_force_i;
		end else begin
			sforce_d = force_q;
		end
	end

	// stop sequence registers and motion outputs
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= OTLH_ST_IDLE;
			method_q <= OTLH_M_NONE;
			hold_q <= OTLH_H_NONE;
			sforce_q <= '0;
			fwd_en_q <= 1'b0;
			rev_en_q <= 1'b0;
			fwd_otf_q <= 1'b0;
			rev_otf_q <= 1'b0;
			clamp_q <= 1'b0;
			ctl_off_q <= 1'b0;
		end else begin
			state_q <= state_d;
			method_q <= method_d;
			hold_q <= hold_d;
			sforce_q <= sforce_d;
			fwd_en_q <= !fwd_ot;
			rev_en_q <= !rev_ot;
			fwd_otf_q <= fwd_ot;
			rev_otf_q <= rev_ot;
			clamp_q <= (hold_d == OTLH_H_CLAMP);
			ctl_off_q <= (hold_d == OTLH_H_COAST) || (method_d == OTLH_M_COAST);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register read: data in the cycle after the strobe, zero elsewhere
	always_comb begin
		rdata_d = 32'h0;
		if (reg_re_i) begin
			case (reg_addr_i)
				OTLH_ADDR_CFG: rdata_d = {12'h0, cfg_shadow_q};
				OTLH_ADDR_FORCE: rdata_d = {22'h0, force_q};
				OTLH_ADDR_STATUS: rdata_d = {20'h0, state_q, hold_q, method_q,
					warn_q, rev_ot, fwd_ot, rev_in_s, fwd_in_s};
				OTLH_ADDR_IRQ_STAT: rdata_d = {29'h0, irq_stat_q};
				OTLH_ADDR_IRQ_MASK: rdata_d = {29'h0, irq_mask_q};
				OTLH_ADDR_CODE: rdata_d = {20'h0, OTLH_WARN_CODE};
				default: rdata_d = 32'h0;
			endcase
		end
	end

	// read data register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_q <= 32'h0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs
	assign reg_rdata_o = rdata_q;
	assign fwd_motion_en_o = fwd_en_q;
	assign rev_motion_en_o = rev_en_q;
	assign fwd_overtravel_o = fwd_otf_q;
	assign rev_overtravel_o = rev_otf_q;
	assign stop_method_o = method_q;
	assign hold_mode_o = hold_q;
	assign zero_clamp_o = clamp_q;
	assign control_off_o = ctl_off_q;
	assign stop_force_o = sforce_q;
	assign warn_o = warn_q;
	assign irq_o = irq_q;

endmodule

// file: sim/otlh_checker.sv
// concurrent checks on the overtravel limit handler ports
`timescale 1ns/10ps
module otlh_checker
	import otlh_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic motor_power_on_i,
	input wire logic force_ctrl_i,
	input wire logic motor_stopped_i,
	input wire logic soft_limit_exceeded_i,
	input wire logic [OTLH_FORCE_W-1:0] motor_max_force_i,
	input wire logic [OTLH_AW-1:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_we_i,
	input wire logic reg_re_i,
	input wire logic [31:0] reg_rdata_o,
	input wire logic fwd_motion_en_o,
	input wire logic rev_motion_en_o,
	input wire logic fwd_overtravel_o,
	input wire logic rev_overtravel_o,
	input wire otlh_method_e stop_method_o,
	input wire otlh_hold_e hold_mode_o,
	input wire logic zero_clamp_o,
	input wire logic [OTLH_FORCE_W-1:0] stop_force_o,
	input wire logic warn_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////////////////////////////////
	// stop sequence steps
	sequence s_come_to_rest;
		stop_method_o != OTLH_M_NONE && motor_stopped_i;
	endsequence

	// permission and overtravel flag are complementary
	a_fwd_en_ot: assert property ($past(rst_n_i)
		|-> fwd_motion_en_o != fwd_overtravel_o)
		else $error("forward enable and overtravel agree");
	a_rev_en_ot: assert property ($past(rst_n_i)
		|-> rev_motion_en_o != rev_overtravel_o)
		else $error("reverse enable and overtravel agree");
	// warning stays until a clear command
	a_warn_hold: assert property (warn_o && !(reg_we_i && reg_addr_i == OTLH_ADDR_CMD
		&& reg_wdata_i[OTLH_CMD_CLR_WARN]) |=> warn_o)
		else $error("warning dropped without clear");
	a_warn_power: assert property (!warn_o && !motor_power_on_i && !soft_limit_exceeded_i
		|=> !warn_o)
		else $error("warning raised with power off");
	a_code_read: assert property (reg_re_i && reg_addr_i == OTLH_ADDR_CODE
		|=> reg_rdata_o == {20'h0, OTLH_WARN_CODE})
		else $error("warning code read wrong");
	a_force_clamp: assert property (1'b1 |=> stop_force_o <= $past(motor_max_force_i))
		else $error("stop force above motor maximum");
	a_force_ceiling: assert property (stop_force_o <= OTLH_FORCE_MAX)
		else $error("stop force above ceiling");
	a_clamp_hold: assert property (zero_clamp_o == (hold_mode_o == OTLH_H_CLAMP))
		else $error("zero clamp disagrees with hold mode");
	a_no_decel: assert property ($rose(stop_method_o == OTLH_M_DECEL)
		|-> !$past(force_ctrl_i))
		else $error("deceleration under force control");
	a_force_coast: assert property ($rose(hold_mode_o != OTLH_H_NONE) && $past(force_ctrl_i)
		|-> hold_mode_o == OTLH_H_COAST)
		else $error("force control hold not coast");
	a_stop_hold: assert property (s_come_to_rest |=> hold_mode_o != OTLH_H_NONE)
		else $error("no hold after motor at rest");
endmodule

bind otlh_top otlh_checker u_chk (.clk_i, .rst_n_i, .motor_power_on_i, .force_ctrl_i,
	.motor_stopped_i, .soft_limit_exceeded_i, .motor_max_force_i, .reg_addr_i, .reg_wdata_i,
	.reg_we_i, .reg_re_i, .reg_rdata_o, .fwd_motion_en_o, .rev_motion_en_o, .fwd_overtravel_o,
	.rev_overtravel_o, .stop_method_o, .hold_mode_o, .zero_clamp_o, .stop_force_o, .warn_o);

// file: sim/otlh_far_model.sv
// far side: limit switches, host reference and a load that comes to rest
`timescale 1ns/10ps
module otlh_far_model
	import otlh_pkg::*;
#(
	parameter int STOP_CYC = 6
) (
	input wire logic clk_i,
	input wire otlh_method_e stop_method_i,
	input wire otlh_hold_e hold_mode_i,
	output logic fwd_sw_o,
	output logic rev_sw_o,
	output logic ref_fwd_o,
	output logic ref_rev_o,
	output logic stopped_o
);
	int cnt = 0;

	// normally closed switches start closed, no reference
	initial begin
		fwd_sw_o = 1'b1;
		rev_sw_o = 1'b1;
		ref_fwd_o = 1'b0;
		ref_rev_o = 1'b0;
	end

	// load rests a while after a stop begins, stays at rest while held
	always @(posedge clk_i) begin
		cnt <= (stop_method_i != OTLH_M_NONE) ? cnt + 1 : 0;
		stopped_o <= (cnt >= STOP_CYC) || (hold_mode_i != OTLH_H_NONE);
	end

	// switch levels, high is closed
	task automatic sw(input logic f, input logic r);
		@(posedge clk_i);
		fwd_sw_o <= f;
		rev_sw_o <= r;
	endtask

	// reference direction, both low is none
	task automatic dir(input logic f, input logic r);
		@(posedge clk_i);
		ref_fwd_o <= f;
		ref_rev_o <= r;
	endtask
endmodule

// file: sim/otlh_top_test.sv
// self-checking bench for the overtravel limit handler
`timescale 1ns/10ps
module otlh_top_test
	import otlh_pkg::*;
();
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic motor_power_on_i = 1'b1;
	logic force_ctrl_i = 1'b0;
	logic soft_limit_exceeded_i = 1'b0;
	logic [OTLH_FORCE_W-1:0] motor_max_force_i = 10'h12c;
	logic [OTLH_AW-1:0] reg_addr_i = 5'h00;
	logic [31:0] reg_wdata_i = 32'h0;
	logic reg_we_i = 1'b0;
	logic reg_re_i = 1'b0;
	logic [31:0] reg_rdata_o;
	logic fwd_limit_in_i, rev_limit_in_i, ref_fwd_i, ref_rev_i, motor_stopped_i;
	logic fwd_motion_en_o, rev_motion_en_o, fwd_overtravel_o, rev_overtravel_o;
	logic zero_clamp_o, control_off_o, warn_o, irq_o;
	logic [OTLH_FORCE_W-1:0] stop_force_o;
	otlh_method_e stop_method_o;
	otlh_hold_e hold_mode_o;
	int num_errors = 0;
	int comparisons = 0;
	int i, k;
	localparam logic [7:0] DIG [7] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h20, 8'h10, 8'h12};
	localparam logic [6:0] FC = 7'h60;
	localparam otlh_method_e EM [7] = '{OTLH_M_BRAKE, OTLH_M_BRAKE, OTLH_M_COAST, OTLH_M_DECEL,
		OTLH_M_DECEL, OTLH_M_BRAKE, OTLH_M_COAST};
	localparam otlh_hold_e EH [7] = '{OTLH_H_BRAKE, OTLH_H_COAST, OTLH_H_COAST, OTLH_H_CLAMP,
		OTLH_H_COAST, OTLH_H_COAST, OTLH_H_COAST};

	otlh_top DUT (.clk_i, .rst_n_i, .fwd_limit_in_i, .rev_limit_in_i, .motor_power_on_i,
		.force_ctrl_i, .motor_stopped_i, .soft_limit_exceeded_i, .motor_max_force_i, .ref_fwd_i,
		.ref_rev_i, .reg_addr_i, .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o,
		.fwd_motion_en_o, .rev_motion_en_o, .fwd_overtravel_o, .rev_overtravel_o,
		.stop_method_o, .hold_mode_o, .zero_clamp_o, .control_off_o, .stop_force_o,
		.warn_o, .irq_o);

	otlh_far_model far (.clk_i, .stop_method_i(stop_method_o), .hold_mode_i(hold_mode_o),
		.fwd_sw_o(fwd_limit_in_i), .rev_sw_o(rev_limit_in_i), .ref_fwd_o(ref_fwd_i),
		.ref_rev_o(ref_rev_i), .stopped_o(motor_stopped_i));

	// 10 MHz clock
	always #50 clk_i = ~clk_i;

	////////////////////////////////////////////////////////////////////////////
	// access and compare tasks
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_we_i <= 1'b1;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge clk_i);
		reg_we_i <= 1'b0;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask

	// read data stand in the cycle after the strobe
	task automatic rdchk(input string n, input logic [4:0] a, input logic [31:0] e);
		@(posedge clk_i);
		reg_re_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge clk_i);
		reg_re_i <= 1'b0;
		@(posedge clk_i);
		chk(n, e, reg_rdata_o);
	endtask

	task automatic complete_run();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic guard(input int n);
		if (n >= 40) begin
			num_errors++;
			complete_run();
		end
	endtask

	// cut a hang short
	initial begin
		#5ms;
		num_errors++;
		complete_run();
	end

	////////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		tick(6);
		rst_n_i <= 1'b1;
		tick(5);
		rdchk("cfg", OTLH_ADDR_CFG, 32'h21);
		rdchk("force", OTLH_ADDR_FORCE, 32'h320);
		rdchk("code", OTLH_ADDR_CODE, 32'h9a0);
		rdchk("unmapped", 5'h1c, 32'h0);
		rdchk("status", OTLH_ADDR_STATUS, 32'h203);
		chk("fwd en", 32'h1, 32'(fwd_motion_en_o));
		chk("force out", 32'h12c, 32'(stop_force_o));
		wr(OTLH_ADDR_FORCE, 32'h64);
		tick(2);
		chk("force out", 32'h64, 32'(stop_force_o));
		wr(OTLH_ADDR_FORCE, 32'h3ff);
		rdchk("force", OTLH_ADDR_FORCE, 32'h320);
		motor_max_force_i <= 10'h3ff;
		tick(3);
		chk("force out", 32'h320, 32'(stop_force_o));
		// detection off: one way blocked, the other open
		far.sw(1'b0, 1'b1);
		tick(6);
		chk("fwd en", 32'h0, 32'(fwd_motion_en_o));
		chk("rev en", 32'h1, 32'(rev_motion_en_o));
		chk("warn", 32'h0, 32'(warn_o));
		far.sw(1'b1, 1'b0);
		tick(6);
		chk("rev ot", 32'h1, 32'(rev_overtravel_o));
		chk("fwd en", 32'h1, 32'(fwd_motion_en_o));
		far.sw(1'b1, 1'b1);
		// detection on, overtravel against and then along the reference
		wr(OTLH_ADDR_CFG, 32'h10021);
		far.dir(1'b0, 1'b1);
		far.sw(1'b0, 1'b1);
		tick(6);
		chk("warn", 32'h0, 32'(warn_o));
		far.sw(1'b1, 1'b1);
		tick(6);
		wr(OTLH_ADDR_IRQ_MASK, 32'h0);
		wr(OTLH_ADDR_IRQ_STAT, 32'h7);
		far.dir(1'b1, 1'b0);
		far.sw(1'b0, 1'b1);
		tick(6);
		chk("warn", 32'h1, 32'(warn_o));
		chk("irq", 32'h0, 32'(irq_o));
		rdchk("irq stat", OTLH_ADDR_IRQ_STAT, 32'h3);
		wr(OTLH_ADDR_IRQ_MASK, 32'h1);
		tick(2);
		chk("irq", 32'h1, 32'(irq_o));
		wr(OTLH_ADDR_IRQ_STAT, 32'h7);
		tick(2);
		chk("irq", 32'h0, 32'(irq_o));
		far.sw(1'b1, 1'b1);
		tick(6);
		chk("warn", 32'h1, 32'(warn_o));
		wr(OTLH_ADDR_CMD, 32'h1);
		tick(2);
		chk("warn", 32'h0, 32'(warn_o));
		// no reference; clear during overtravel, then recur
		far.dir(1'b0, 1'b0);
		far.sw(1'b0, 1'b1);
		tick(6);
		chk("warn", 32'h1, 32'(warn_o));
		wr(OTLH_ADDR_CMD, 32'h1);
		tick(6);
		chk("warn", 32'h0, 32'(warn_o));
		far.sw(1'b1, 1'b1);
		tick(6);
		far.sw(1'b1, 1'b0);
		tick(1);
		far.sw(1'b1, 1'b1);
		tick(6);
		chk("warn", 32'h1, 32'(warn_o));
		wr(OTLH_ADDR_CMD, 32'h1);
		// power off, then on during overtravel
		motor_power_on_i <= 1'b0;
		far.sw(1'b1, 1'b0);
		tick(6);
		chk("warn", 32'h0, 32'(warn_o));
		motor_power_on_i <= 1'b1;
		tick(6);
		chk("warn", 32'h0, 32'(warn_o));
		far.sw(1'b1, 1'b1);
		tick(6);
		soft_limit_exceeded_i <= 1'b1;
		tick(1);
		soft_limit_exceeded_i <= 1'b0;
		tick(3);
		chk("warn", 32'h1, 32'(warn_o));
		// limit config waits for restart
		wr(OTLH_ADDR_CFG, 32'h88);
		far.sw(1'b0, 1'b0);
		tick(20);
		chk("fwd ot", 32'h1, 32'(fwd_overtravel_o));
		chk("rev ot", 32'h1, 32'(rev_overtravel_o));
		wr(OTLH_ADDR_CMD, 32'h3);
		tick(6);
		chk("fwd en", 32'h1, 32'(fwd_motion_en_o));
		chk("rev en", 32'h1, 32'(rev_motion_en_o));
		far.sw(1'b1, 1'b1);
		// every stop method and mode after stopping
		for (k = 0; k < 7; k++) begin
			force_ctrl_i <= FC[k];
			wr(OTLH_ADDR_CFG, {16'h0, DIG[k], 8'h21});
			wr(OTLH_ADDR_CMD, 32'h2);
			far.sw(1'b0, 1'b1);
			for (i = 0; i < 40 && stop_method_o === OTLH_M_NONE; i++) tick(1);
			guard(i);
			chk("method", 32'(EM[k]), 32'(stop_method_o));
			for (i = 0; i < 40 && hold_mode_o === OTLH_H_NONE; i++) tick(1);
			guard(i);
			chk("hold", 32'(EH[k]), 32'(hold_mode_o));
			chk("clamp", 32'(EH[k] == OTLH_H_CLAMP), 32'(zero_clamp_o));
			chk("coast", 32'(EH[k] == OTLH_H_COAST), 32'(control_off_o));
			far.sw(1'b1, 1'b1);
			tick(8);
		end
		complete_run();
	end
endmodule
